/* File: hdl/cscp_pkg.sv */
/*
 * Package for the codec serial control port: frame layout, command codes,
 * memory size, timing figures and the struct that carries memory writes.
 * Assumes a 100 MHz core clock.
 */
package cscp_pkg;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam int MEM_WORDS = 256;
	localparam logic [7:0] MEM_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int LINK_MAX_KBPS = 4096;
	localparam int FETCH_WAIT_NS = 1500;
	localparam int FETCH_WAIT_CYC = (FETCH_WAIT_NS * SYS_CLK_MHZ) / 1000;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_LEN,
		ST_WDATA,
		ST_WAIT_RESP,
		ST_RESP,
		ST_IGNORE
	} cscp_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} cscp_wr_s;
endpackage

/* File: hdl/cscp_port.sv */
/*
 * Codec serial control port slave: select, shift clock, serial in and a
 * tri-state serial out, all sampled by the 100 MHz core clock.
 * Assumes the shift clock is at least eight times slower than sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module cscp_port (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Serial control link
	input wire logic ctl_shift_clock,
	input wire logic ctl_select_n,
	input wire logic ctl_serial_in,
	output logic ctl_serial_out,
	output logic ctl_serial_out_en,
	// Strap
	input wire logic framing_mode_strap,
	// Control memory view and write stream
	input wire logic [7:0] mem_rd_addr,
	output logic [7:0] mem_rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output cscp_pkg::cscp_wr_s wr_data,
	output logic abort_pulse
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] clk_s_q, sel_s_q, din_s_q, strap_s_q;
	logic clk_prev_q;
	// Every pin crosses two stages before edge logic reads it; a false
	// clock edge just after reset finds select high and does no harm
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_s_q <= 2'h0;
			sel_s_q <= 2'h3;
			din_s_q <= 2'h0;
			strap_s_q <= 2'h3;
			clk_prev_q <= 1'b0;
		end else begin
			clk_s_q <= {clk_s_q[0], ctl_shift_clock};
			sel_s_q <= {sel_s_q[0], ctl_select_n};
			din_s_q <= {din_s_q[0], ctl_serial_in};
			strap_s_q <= {strap_s_q[0], framing_mode_strap};
			clk_prev_q <= clk_s_q[1];
		end
	end

	logic byte_mode;
	logic rise, fall, sample_edge, drive_edge;
	logic sel_act;
	assign byte_mode = !strap_s_q[1];
	assign rise = clk_s_q[1] && !clk_prev_q;
	assign fall = !clk_s_q[1] && clk_prev_q;
	// Byte mode samples on the falling edge and drives on the rising one
	assign sample_edge = byte_mode ? fall : rise;
	assign drive_edge = byte_mode ? rise : fall;
	assign sel_act = !sel_s_q[1];

	// ----------------------------------------------------------------
	// Select framing, sampled only on shift clock edges
	// ----------------------------------------------------------------
	logic sel_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] sh_q;
	logic byte_done, sel_end, sel_start, frame_bad;
	// Select is judged only on sample edges: with the clock stopped a
	// resynchronising pulse goes unseen
	assign sel_start = sample_edge && sel_act && !sel_q;
	assign sel_end = sample_edge && !sel_act && sel_q;
	assign frame_bad = sel_end && (bit_cnt_q != 3'h0);
	assign byte_done = sample_edge && sel_act && (bit_cnt_q == cscp_pkg::BIT_LAST);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q <= 1'b0;
			bit_cnt_q <= 3'h0;
			sh_q <= 8'h00;
		end else if (sample_edge) begin
			sel_q <= sel_act;
			if (sel_act) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				sh_q <= {din_s_q[1], sh_q[7:1]};
			end else begin
				bit_cnt_q <= 3'h0;
			end
		end
	end

	logic [7:0] rx_byte;
	assign rx_byte = {din_s_q[1], sh_q[7:1]};

	// ----------------------------------------------------------------
	// Frame decoder
	// ----------------------------------------------------------------
	cscp_pkg::cscp_state_e st_q;
	logic [7:0] cmd_q, addr_q, len_q;
	logic [15:0] wait_q;
	logic fifo_in_ready;
	logic push;
	logic resp_go, wait_load;
	// An early second select is not answered: memory data is only
	// trusted once the fetch wait has run out
	assign resp_go = sel_start && st_q == cscp_pkg::ST_WAIT_RESP
	    && wait_q == 16'h0000;
	assign wait_load = st_q == cscp_pkg::ST_LEN && byte_done
	    && rx_byte != 8'h00 && cmd_q == cscp_pkg::CMD_READ;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			wait_q <= 16'h0000;
		else if (wait_load)
			wait_q <= 16'(cscp_pkg::FETCH_WAIT_CYC);
		else if (wait_q != 16'h0000)
			wait_q <= wait_q - 16'h0001;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= cscp_pkg::ST_CMD;
			cmd_q <= 8'h00;
			addr_q <= 8'h00;
			len_q <= 8'h00;
		end else if (frame_bad) begin
			st_q <= cscp_pkg::ST_CMD;
		end else begin
			case (st_q)
			cscp_pkg::ST_CMD: if (byte_done) begin
				cmd_q <= rx_byte;
				st_q <= cscp_pkg::ST_ADDR;
			end
			cscp_pkg::ST_ADDR: if (byte_done) begin
				addr_q <= rx_byte;
				st_q <= cscp_pkg::ST_LEN;
			end
			cscp_pkg::ST_LEN: if (byte_done) begin
				len_q <= rx_byte;
				if (rx_byte == 8'h00)
					st_q <= cscp_pkg::ST_IGNORE;
				else if (cmd_q == cscp_pkg::CMD_WRITE)
					st_q <= cscp_pkg::ST_WDATA;
				else if (cmd_q == cscp_pkg::CMD_READ)
					st_q <= cscp_pkg::ST_WAIT_RESP;
				else
					st_q <= cscp_pkg::ST_IGNORE;
			end
			cscp_pkg::ST_WDATA: if (byte_done && fifo_in_ready) begin
				addr_q <= addr_q + 8'h01;
				len_q <= len_q - 8'h01;
				if (len_q == 8'h01)
					st_q <= cscp_pkg::ST_IGNORE;
			end
			// Normal mode drops select after the length byte; byte mode
			// already drops it after every byte
			cscp_pkg::ST_WAIT_RESP: if (resp_go)
				st_q <= cscp_pkg::ST_RESP;
			cscp_pkg::ST_RESP: if (byte_done) begin
				addr_q <= addr_q + 8'h01;
				len_q <= len_q - 8'h01;
				if (len_q == 8'h01)
					st_q <= cscp_pkg::ST_IGNORE;
			end
			cscp_pkg::ST_IGNORE: if (sel_end)
				st_q <= cscp_pkg::ST_CMD;
			default: st_q <= cscp_pkg::ST_CMD;
			endcase
			// Normal mode: select release ends a frame, except in ST_WAIT_RESP and ST_RESP
			if (sel_end && !byte_mode
			    && st_q != cscp_pkg::ST_WAIT_RESP
			    && st_q != cscp_pkg::ST_RESP)
				st_q <= cscp_pkg::ST_CMD;
		end
	end

	// ----------------------------------------------------------------
	// Two-entry write buffer; a stall holds the incoming byte's state
	// ----------------------------------------------------------------
	// A stall longer than two byte times drops the next write byte, so
	// the consumer should keep wr_ready high while a frame arrives
	cscp_pkg::cscp_wr_s buf_q [2];
	logic [1:0] cnt_q;
	logic rd_ptr_q, wr_ptr_q;
	logic pop;
	assign fifo_in_ready = cnt_q != cscp_pkg::BUF_DEPTH;
	assign push = st_q == cscp_pkg::ST_WDATA && byte_done && fifo_in_ready;
	assign wr_valid = cnt_q != 2'h0;
	assign pop = wr_valid && wr_ready;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 2'h0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			if (push) begin
				buf_q[wr_ptr_q] <= '{addr: addr_q, data: rx_byte};
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop)
				rd_ptr_q <= !rd_ptr_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	assign wr_data = buf_q[rd_ptr_q];

	// ----------------------------------------------------------------
	// Control memory
	// ----------------------------------------------------------------
	logic [7:0] mem_q [cscp_pkg::MEM_WORDS];
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < cscp_pkg::MEM_WORDS; i++)
				mem_q[i] <= cscp_pkg::MEM_RESET;
		end else if (pop) begin
			mem_q[wr_data.addr] <= wr_data.data;
		end
	end

	logic [7:0] rd_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			rd_q <= 8'h00;
		else
			rd_q <= mem_q[mem_rd_addr];
	end
	assign mem_rd_data = rd_q;

	// ----------------------------------------------------------------
	// Response shifter
	// ----------------------------------------------------------------
	logic [7:0] tx_q;
	logic out_q, oe_q;
	logic responding;
	assign responding = st_q == cscp_pkg::ST_RESP && sel_act;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_q <= 8'h00;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			// Enable opens with the first bit so it is never read undriven
			oe_q <= responding || resp_go;
			if (resp_go) begin
				tx_q <= {1'b0, mem_q[addr_q][7:1]};
				out_q <= mem_q[addr_q][0];
			end else if (responding && byte_done) begin
				// Only queue the next byte: the last bit of this one must
				// stand until the master's next drive edge
				tx_q <= mem_q[addr_q + 8'h01];
			end else if (responding && drive_edge) begin
				out_q <= tx_q[0];
				tx_q <= {1'b0, tx_q[7:1]};
			end
		end
	end
	assign ctl_serial_out = out_q;
	assign ctl_serial_out_en = oe_q;

	// One pulse per frame cut off mid-byte; decoding restarts by itself
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			abort_pulse <= 1'b0;
		else
			abort_pulse <= frame_bad;
	end
endmodule

`default_nettype wire

/* File: testbench/cscp_master.sv */
/* Master controller model for the serial control link.
   Driven by hierarchical task calls from tb_top; 80 ns shift clock. */
`timescale 1ns/1ps
`default_nettype none
module cscp_master (
	// Link to the port
	output logic ctl_shift_clock,
	output logic ctl_select_n,
	output logic ctl_serial_in,
	input wire logic ctl_serial_out,
	input wire logic ctl_serial_out_en
);
	logic bm;
	int gap_ns;
	initial begin
		ctl_shift_clock = 1'b1;
		ctl_select_n = 1'b1;
		ctl_serial_in = 1'b0;
		bm = 1'b0;
		gap_ns = 0;
	end
	// Drive edge first, sample edge halfway; byte mode flips the phase
	task automatic cyc(input logic sel, input logic d);
		ctl_select_n <= sel;
		ctl_serial_in <= d;
		ctl_shift_clock <= bm;
		#40;
		ctl_shift_clock <= ~bm;
		#40;
	endtask
	// Bit i of tx goes out i-th, so bytes and bits both go LSB first
	task automatic xfer(input logic [63:0] tx, input int nbits,
		input int post, output logic [63:0] rx, output logic [63:0] oe);
		rx = '0;
		oe = '0;
		for (int i = 0; i < nbits; i++) begin
			cyc(1'b0, tx[i]);
			// A released line has no pull: show it inverted so that a
			// bit taken while undriven is caught
			rx[i] = ctl_serial_out_en ? ctl_serial_out : ~ctl_serial_out;
			oe[i] = ctl_serial_out_en;
			if (i % 8 == 3 && gap_ns > 0)
				#(gap_ns);
			if (bm && i % 8 == 7 && i < nbits - 1)
				cyc(1'b1, ~tx[i]);
		end
		// Idle line toggles so a stale level is never mistaken for data
		for (int i = 0; i < post; i++)
			cyc(1'b1, ~ctl_serial_in);
	endtask
endmodule
`default_nettype wire

/* File: testbench/cscp_port_asserts.sv */
/* Checker for the serial control port outputs.
   Bound to cscp_port from tb_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module cscp_port_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Link and write stream
	input wire logic ctl_select_n,
	input wire logic ctl_serial_out,
	input wire logic ctl_serial_out_en,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire cscp_pkg::cscp_wr_s wr_data,
	input wire logic abort_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_oe_rise;
		$rose(ctl_serial_out_en) |-> !ctl_select_n;
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("output enabled while select high");
	property p_oe_fall;
		$fell(ctl_serial_out_en) |-> ctl_select_n;
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("output released while select low");
	property p_oe_off;
		ctl_select_n [*8] |=> !ctl_serial_out_en;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output still driven after select release");
	property p_abort_width;
		abort_pulse |=> !abort_pulse;
	endproperty
	a_abort_width: assert property (p_abort_width)
		else $error("abort pulse longer than one cycle");
	property p_abort_sel;
		abort_pulse |-> ctl_select_n && !ctl_serial_out_en;
	endproperty
	a_abort_sel: assert property (p_abort_sel)
		else $error("abort without select release");
	property p_wr_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write entry lost while stalled");
	property p_bit_hold;
		ctl_serial_out_en && $changed(ctl_serial_out)
			|=> $stable(ctl_serial_out) [*3];
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("serial bit too short");
	property p_reset_out;
		$rose(reset_n) |-> !ctl_serial_out_en && !wr_valid && !abort_pulse;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
/* Self-checking bench for cscp_port with a master model.
   Assumes the cscp_pkg constants and a 100 MHz sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk, reset_n, framing_mode_strap, wr_ready;
	logic ctl_shift_clock, ctl_select_n, ctl_serial_in;
	logic ctl_serial_out, ctl_serial_out_en, wr_valid, abort_pulse;
	logic [7:0] mem_rd_addr, mem_rd_data;
	logic [63:0] rx, oe;
	cscp_pkg::cscp_wr_s wr_data;
	cscp_pkg::cscp_wr_s got[$];
	int bad_count, checked, aborts;
	always #5 sys_clk = ~sys_clk;
	cscp_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.ctl_shift_clock(ctl_shift_clock), .ctl_select_n(ctl_select_n),
		.ctl_serial_in(ctl_serial_in), .ctl_serial_out(ctl_serial_out),
		.ctl_serial_out_en(ctl_serial_out_en),
		.framing_mode_strap(framing_mode_strap), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .abort_pulse(abort_pulse));
	cscp_master i_mst (.ctl_shift_clock(ctl_shift_clock),
		.ctl_select_n(ctl_select_n), .ctl_serial_in(ctl_serial_in),
		.ctl_serial_out(ctl_serial_out),
		.ctl_serial_out_en(ctl_serial_out_en));
	always @(posedge sys_clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			got.push_back(wr_data);
		if (abort_pulse === 1'b1)
			aborts++;
	end
	task automatic chk(input string what, input logic [63:0] e,
		input logic [63:0] a);
		checked++;
		if (a !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, a);
		end
	endtask
	task automatic chk_wr(input logic [15:0] e);
		logic [15:0] v;
		v = 'x;
		if (got.size() > 0)
			v = got.pop_front();
		chk("write entry", {48'h0, e}, {48'h0, v});
	endtask
	task automatic chk_mem(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) mem_rd_addr <= a;
		repeat (3) @(posedge sys_clk);
		chk("memory", {56'h0, e}, {56'h0, mem_rd_data});
	endtask
	task automatic t_write;
		i_mst.gap_ns = 400;
		i_mst.xfer(64'hAA_01_05_01, 32, 2, rx, oe);
		i_mst.gap_ns = 0;
		repeat (4) @(posedge sys_clk);
		chk("write enable", 0, oe);
		chk_wr(16'h05AA);
		chk_mem(8'h05, 8'hAA);
		$display("write test done");
	endtask
	task automatic t_stall;
		@(posedge sys_clk) wr_ready <= 1'b0;
		i_mst.xfer(64'h22_11_02_10_01, 40, 2, rx, oe);
		repeat (20) @(posedge sys_clk);
		chk("stalled pops", 0, got.size());
		chk("valid held", 1, wr_valid);
		@(posedge sys_clk) wr_ready <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk_wr(16'h1011);
		chk_wr(16'h1122);
		chk("drained", 0, wr_valid);
		$display("stall test done");
	endtask
	task automatic t_read;
		i_mst.xfer(64'h02_10_02, 24, 24, rx, oe);
		chk("cmd enable", 0, oe);
		i_mst.xfer(64'h0501, 16, 2, rx, oe);
		chk("read data", 64'h2211, rx);
		chk("resp enable", 64'hFFFF, oe);
		chk("input ignored", 0, got.size());
		$display("read test done");
	endtask
	task automatic t_abort;
		i_mst.xfer(64'h1F, 5, 2, rx, oe);
		chk("aborts", 1, aborts);
		i_mst.xfer(64'h5A_01_20_01, 32, 2, rx, oe);
		repeat (4) @(posedge sys_clk);
		chk_wr(16'h205A);
		$display("abort test done");
	endtask
	task automatic t_byte;
		@(posedge sys_clk) framing_mode_strap <= 1'b0;
		i_mst.bm = 1'b1;
		i_mst.xfer(64'hC3_01_30_01, 32, 2, rx, oe);
		repeat (4) @(posedge sys_clk);
		chk_wr(16'h30C3);
		i_mst.xfer(64'h1F, 5, 2, rx, oe);
		chk("aborts", 2, aborts);
		i_mst.xfer(64'h01_30_02, 24, 24, rx, oe);
		i_mst.xfer(64'h0, 8, 2, rx, oe);
		chk("byte read", 64'hC3, rx);
		@(posedge sys_clk) framing_mode_strap <= 1'b1;
		i_mst.bm = 1'b0;
		$display("byte mode test done");
	endtask
	task automatic t_reset;
		@(posedge sys_clk) reset_n <= 1'b0;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		i_mst.xfer(64'h0, 0, 2, rx, oe);
		chk_mem(8'h05, 8'h00);
		chk("reset enable", 0, ctl_serial_out_en);
		$display("reset test done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		framing_mode_strap = 1'b1;
		wr_ready = 1'b1;
		mem_rd_addr = 8'h00;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_write();
		t_stall();
		t_read();
		t_abort();
		t_byte();
		t_reset();
		end_sim();
	end
endmodule
bind cscp_port cscp_port_asserts i_chk (.sys_clk(sys_clk),
	.reset_n(reset_n), .ctl_select_n(ctl_select_n),
	.ctl_serial_out(ctl_serial_out), .ctl_serial_out_en(ctl_serial_out_en),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
	.abort_pulse(abort_pulse));
`default_nettype wire
